// ---- mission_datalog_consts.svh ----
// constants shared by the mission datalog sequencer files
`ifndef MISSION_DATALOG_CONSTS_SVH
`define MISSION_DATALOG_CONSTS_SVH

// log memory geometry in bytes
`define LOG_ADDR_W       13
`define LOG_SIZE_W       14
`define LOG_FULL_BYTES   14'h2000
`define LOG_HALF_BYTES   14'h1000
`define LOG_MIXED_ENTRY  14'h0A00
`define LOG_MIXED_TOP    14'h1F00
`define LOG_ZERO         14'h0000

// timebase
`define SECS_PER_MIN     6'h3C
`define RATE_W           14
`define RATE_MIN         14'h0001
`define DELAY_W          16
`define DELAY_ZERO       16'h0000

// password locations read as zero
`define PW_FIRST_ADDR    16'h0228
`define PW_LAST_ADDR     16'h0237
`define PW_READ_BYTE     8'h00

// alarm flag positions
`define ALM_TEMP_LOW     0
`define ALM_TEMP_HIGH    1

// rtc date and time word
`define RTC_W            48

`endif

// ---- mission_datalog_pkg.sv ----
// shared types for the mission datalog sequencer
`include "mission_datalog_consts.svh"

package mission_datalog_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_DELAY,
        ST_ARMED,
        ST_RUN
    } mission_state_e;

    typedef struct packed {
        logic                     temperature_log_enable;
        logic                     data_log_enable;
        logic                     temp_wide;
        logic                     data_wide;
        logic                     wrap_enable;
        logic                     fast_rate_select;
        logic                     alarm_triggered_start;
        logic [3:0]               alarm_enable;
        logic [`RATE_W-1:0]       sample_rate;
        logic [`DELAY_W-1:0]      start_delay;
    } log_cfg_s;

    typedef struct packed {
        logic                     we;
        logic [`LOG_ADDR_W-1:0]   addr;
        logic [7:0]               data;
    } log_wr_s;

endpackage

// ---- interval_counter.sv ----
// counts enable ticks and strobes once every period ticks
`timescale 1ns/1ps
`include "mission_datalog_consts.svh"

module interval_counter #(
    parameter int W = `RATE_W
) (
    // clock and reset
    input  wire logic         clk_in,
    input  wire logic         arst_n_in,
    // control
    input  wire logic         restart_in,
    input  wire logic         tick_in,
    input  wire logic [W-1:0] period_in,
    // strobe
    output logic              done_out
);
    logic [W-1:0] count_reg;
    logic [W:0]   count_inc;

    assign count_inc = {1'b0, count_reg} + {{W{1'b0}}, 1'b1};
    assign done_out  = tick_in && !restart_in
                       && (count_inc >= {1'b0, period_in});

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            count_reg <= '0;
        end else if (restart_in || done_out) begin
            count_reg <= '0;
        end else if (tick_in) begin
            count_reg <= count_inc[W-1:0];
        end
    end

endmodule // interval_counter

// ---- mission_datalog_sequencer.sv ----
// mission sequencing and datalog placement for the logger
// Contract
// - one channel uses whole 8192/4096 memory
// - same widths: two equal 4096/2048 sections
// - mixed widths: 2560 entries each, top 256 unused
// - two-byte entry: high byte at lower address
// - no wrap: full section stops being written
// - wrap: restart at section start, overwrite oldest
// - enabled tripped alarm flags conditional search
// - sample rate unsigned 14 bits, 1..16383
// - interval in seconds if fast, else minutes
// - start sets active, clears cleared flag
// - delayed start: stamp, first entry, then interval
// - delayed mode entries bump both counters
// - alarm start: after delay, sample, device count
// - alarm entry first, stamp one interval later
// - general memory writable during a mission
// - reads allowed anytime, passwords read 00h
// - mission refuses copy into register pages
`timescale 1ns/1ps
`include "mission_datalog_consts.svh"

module mission_datalog_sequencer
    import mission_datalog_pkg::*;
#(
    parameter int CNT_W = 24
) (
    // clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 arst_n_in,
    // real-time clock
    input  wire logic                 sec_tick_in,
    input  wire logic                 oscillator_run_bit_in,
    input  wire logic [`RTC_W-1:0]    rtc_now_in,
    // configuration and commands
    input  wire log_cfg_s             cfg_in,
    input  wire logic                 start_cmd_in,
    input  wire logic                 stop_cmd_in,
    input  wire logic                 clear_cmd_in,
    // converters and alarm comparators
    input  wire logic [15:0]          temp_value_in,
    input  wire logic [15:0]          data_value_in,
    input  wire logic [3:0]           alarm_trip_in,
    output logic                      sample_req_out,
    // mission status
    output logic                      mission_active_flag_out,
    output logic                      memory_cleared_flag_out,
    output logic [3:0]                alarm_flags_out,
    output logic                      alarmed_out,
    output logic [`RTC_W-1:0]         mission_stamp_out,
    output logic [CNT_W-1:0]          mission_count_out,
    output logic [CNT_W-1:0]          device_count_out,
    // log memory write port
    output log_wr_s                   log_wr_out,
    // host memory access
    input  wire logic [15:0]          host_rd_addr_in,
    input  wire logic [7:0]           mem_rd_data_in,
    output logic [7:0]                host_rd_data_out,
    input  wire logic                 gp_wr_req_in,
    output logic                      gp_wr_ok_out,
    input  wire logic                 copy_req_in,
    input  wire logic                 copy_reg_page_in,
    output logic                      copy_ok_out
);
    mission_state_e          state_reg;
    mission_state_e          state_next;
    logic                    active_reg;
    logic                    cleared_reg;
    logic [3:0]              alarm_reg;
    logic [`RTC_W-1:0]       stamp_reg;
    logic                    stamp_pending_reg;
    logic [CNT_W-1:0]        mission_cnt_reg;
    logic [CNT_W-1:0]        device_cnt_reg;
    logic [`LOG_SIZE_W-1:0]  ptr_t_reg;
    logic [`LOG_SIZE_W-1:0]  ptr_d_reg;
    logic                    full_t_reg;
    logic                    full_d_reg;
    logic                    wr_busy_reg;
    logic [1:0]              wr_idx_reg;
    logic [15:0]             temp_hold_reg;
    logic [15:0]             data_hold_reg;
    log_wr_s                 wr_reg;
    logic [7:0]              rd_data_reg;

    logic                    sec_tick;
    logic                    min_tick;
    logic                    iv_tick;
    logic                    iv_done;
    logic                    dly_done;
    logic [`RATE_W-1:0]      rate_eff;
    logic                    restart_iv;
    logic                    restart_dly;
    logic                    any_channel;
    logic                    temp_alarm_now;
    logic                    begin_now;
    logic                    log_go;
    logic                    dev_inc;
    logic                    mis_inc;
    logic                    stamp_now;
    logic                    stamp_defer;

    logic                    both;
    logic                    mixed;
    logic [`LOG_SIZE_W-1:0]  size_t;
    logic [`LOG_SIZE_W-1:0]  size_d;
    logic [`LOG_SIZE_W-1:0]  base_d;
    logic [`LOG_SIZE_W-1:0]  step_t;
    logic [`LOG_SIZE_W-1:0]  step_d;
    logic [`LOG_SIZE_W-1:0]  ptr_t_adv;
    logic [`LOG_SIZE_W-1:0]  ptr_d_adv;
    logic [`LOG_SIZE_W-1:0]  wr_addr;
    logic [7:0]              wr_byte;
    logic                    wr_en;
    logic                    temp_last;
    logic                    data_last;

    // a stopped oscillator freezes all timing
    assign sec_tick = sec_tick_in && oscillator_run_bit_in;

    interval_counter #(
        .W (6)
    ) u_minute (
        .clk_in     (clk_in),
        .arst_n_in  (arst_n_in),
        .restart_in (1'b0),
        .tick_in    (sec_tick),
        .period_in  (`SECS_PER_MIN),
        .done_out   (min_tick)
    );

    interval_counter #(
        .W (`DELAY_W)
    ) u_delay (
        .clk_in     (clk_in),
        .arst_n_in  (arst_n_in),
        .restart_in (restart_dly),
        .tick_in    (min_tick),
        .period_in  (cfg_in.start_delay),
        .done_out   (dly_done)
    );

    // out-of-range rate zero acts as one
    assign rate_eff = (cfg_in.sample_rate == '0) ? `RATE_MIN
                                                 : cfg_in.sample_rate;
    assign iv_tick  = cfg_in.fast_rate_select ? sec_tick : min_tick;

    interval_counter #(
        .W (`RATE_W)
    ) u_interval (
        .clk_in     (clk_in),
        .arst_n_in  (arst_n_in),
        .restart_in (restart_iv),
        .tick_in    (iv_tick),
        .period_in  (rate_eff),
        .done_out   (iv_done)
    );

    assign any_channel = cfg_in.temperature_log_enable
                         || cfg_in.data_log_enable;
    assign temp_alarm_now =
        (cfg_in.alarm_enable[`ALM_TEMP_LOW]
         && (alarm_reg[`ALM_TEMP_LOW] || alarm_trip_in[`ALM_TEMP_LOW]))
        || (cfg_in.alarm_enable[`ALM_TEMP_HIGH]
         && (alarm_reg[`ALM_TEMP_HIGH] || alarm_trip_in[`ALM_TEMP_HIGH]));

    always_comb begin
        state_next  = state_reg;
        begin_now   = 1'b0;
        log_go      = 1'b0;
        dev_inc     = 1'b0;
        mis_inc     = 1'b0;
        stamp_now   = 1'b0;
        stamp_defer = 1'b0;
        restart_iv  = 1'b0;
        restart_dly = 1'b0;
        unique case (state_reg)
            ST_IDLE: begin
                if (start_cmd_in && any_channel) begin
                    restart_dly = 1'b1;
                    if (cfg_in.start_delay == `DELAY_ZERO) begin
                        begin_now = 1'b1;
                    end else begin
                        state_next = ST_DELAY;
                    end
                end
            end
            ST_DELAY: begin
                if (dly_done) begin
                    begin_now = 1'b1;
                end
            end
            ST_ARMED: begin
                if (iv_done) begin
                    dev_inc = 1'b1;
                    if (temp_alarm_now) begin
                        log_go      = 1'b1;
                        stamp_defer = 1'b1;
                        state_next  = ST_RUN;
                    end
                end
            end
            ST_RUN: begin
                if (iv_done) begin
                    log_go    = 1'b1;
                    dev_inc   = 1'b1;
                    mis_inc   = 1'b1;
                    stamp_now = stamp_pending_reg;
                end
            end
        endcase
        if (begin_now) begin
            restart_iv = 1'b1;
            if (cfg_in.alarm_triggered_start
                && cfg_in.temperature_log_enable) begin
                state_next = ST_ARMED;
            end else begin
                state_next = ST_RUN;
                log_go     = 1'b1;
                dev_inc    = 1'b1;
                mis_inc    = 1'b1;
                stamp_now  = 1'b1;
            end
        end
        if (stop_cmd_in && (state_reg != ST_IDLE)) begin
            state_next = ST_IDLE;
            log_go     = 1'b0;
            dev_inc    = 1'b0;
            mis_inc    = 1'b0;
            stamp_now  = 1'b0;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            active_reg  <= 1'b0;
            cleared_reg <= 1'b0;
        end else if (state_reg == ST_IDLE && state_next != ST_IDLE) begin
            active_reg  <= 1'b1;
            cleared_reg <= 1'b0;
        end else if (stop_cmd_in) begin
            active_reg  <= 1'b0;
        end else if (clear_cmd_in && !active_reg) begin
            cleared_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            alarm_reg <= 4'h0;
        end else begin
            alarm_reg <= ((clear_cmd_in && !active_reg) ? 4'h0 : alarm_reg)
                         | (active_reg ? alarm_trip_in : 4'h0);
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            stamp_reg         <= '0;
            stamp_pending_reg <= 1'b0;
        end else if (stamp_now) begin
            stamp_reg         <= rtc_now_in;
            stamp_pending_reg <= 1'b0;
        end else if (stamp_defer) begin
            stamp_pending_reg <= 1'b1;
        end else if (clear_cmd_in && !active_reg) begin
            stamp_reg         <= '0;
            stamp_pending_reg <= 1'b0;
        end
    end

    // device count survives memory clear
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            mission_cnt_reg <= '0;
            device_cnt_reg  <= '0;
        end else begin
            if (mis_inc) begin
                mission_cnt_reg <= mission_cnt_reg + 1'b1;
            end else if (clear_cmd_in && !active_reg) begin
                mission_cnt_reg <= '0;
            end
            if (dev_inc) begin
                device_cnt_reg <= device_cnt_reg + 1'b1;
            end
        end
    end

    // section layout
    assign both   = cfg_in.temperature_log_enable && cfg_in.data_log_enable;
    assign mixed  = both && (cfg_in.temp_wide != cfg_in.data_wide);
    assign step_t = cfg_in.temp_wide ? 14'h0002 : 14'h0001;
    assign step_d = cfg_in.data_wide ? 14'h0002 : 14'h0001;

    always_comb begin
        if (!both) begin
            size_t = `LOG_FULL_BYTES;
            size_d = `LOG_FULL_BYTES;
            base_d = `LOG_ZERO;
        end else if (!mixed) begin
            size_t = `LOG_HALF_BYTES;
            size_d = `LOG_HALF_BYTES;
            base_d = `LOG_HALF_BYTES;
        end else begin
            // data section ends below the unused top block
            size_t = cfg_in.temp_wide ? (`LOG_MIXED_ENTRY << 1)
                                      : `LOG_MIXED_ENTRY;
            size_d = cfg_in.data_wide ? (`LOG_MIXED_ENTRY << 1)
                                      : `LOG_MIXED_ENTRY;
            base_d = `LOG_MIXED_TOP - size_d;
        end
    end

    assign ptr_t_adv = ptr_t_reg + step_t;
    assign ptr_d_adv = ptr_d_reg + step_d;

    // byte slots: 0 temp high/only, 1 temp low, 2 data high/only, 3 data low
    always_comb begin
        wr_en     = 1'b0;
        wr_addr   = `LOG_ZERO;
        wr_byte   = 8'h00;
        temp_last = 1'b0;
        data_last = 1'b0;
        if (wr_idx_reg[1] == 1'b0) begin
            temp_last = cfg_in.temp_wide ? wr_idx_reg[0] : !wr_idx_reg[0];
            wr_en     = cfg_in.temperature_log_enable
                        && !(full_t_reg && !cfg_in.wrap_enable)
                        && (cfg_in.temp_wide || !wr_idx_reg[0]);
            wr_addr   = ptr_t_reg + {13'h0000, wr_idx_reg[0]};
            wr_byte   = (cfg_in.temp_wide && !wr_idx_reg[0])
                        ? temp_hold_reg[15:8] : temp_hold_reg[7:0];
        end else begin
            data_last = cfg_in.data_wide ? wr_idx_reg[0] : !wr_idx_reg[0];
            wr_en     = cfg_in.data_log_enable
                        && !(full_d_reg && !cfg_in.wrap_enable)
                        && (cfg_in.data_wide || !wr_idx_reg[0]);
            wr_addr   = base_d + ptr_d_reg + {13'h0000, wr_idx_reg[0]};
            wr_byte   = (cfg_in.data_wide && !wr_idx_reg[0])
                        ? data_hold_reg[15:8] : data_hold_reg[7:0];
        end
    end

    // write engine walks four byte slots per sample
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_busy_reg   <= 1'b0;
            wr_idx_reg    <= 2'h0;
            temp_hold_reg <= 16'h0000;
            data_hold_reg <= 16'h0000;
        end else if (log_go) begin
            wr_busy_reg   <= 1'b1;
            wr_idx_reg    <= 2'h0;
            temp_hold_reg <= temp_value_in;
            data_hold_reg <= data_value_in;
        end else if (wr_busy_reg) begin
            wr_idx_reg  <= wr_idx_reg + 2'h1;
            wr_busy_reg <= (wr_idx_reg != 2'h3);
        end
    end

    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wr_reg <= '0;
        end else begin
            wr_reg.we   <= wr_busy_reg && wr_en;
            wr_reg.addr <= wr_addr[`LOG_ADDR_W-1:0];
            wr_reg.data <= wr_byte;
        end
    end

    // write pointers, reset when a mission starts
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            ptr_t_reg  <= `LOG_ZERO;
            ptr_d_reg  <= `LOG_ZERO;
            full_t_reg <= 1'b0;
            full_d_reg <= 1'b0;
        end else if (state_reg == ST_IDLE && start_cmd_in && any_channel) begin
            ptr_t_reg  <= `LOG_ZERO;
            ptr_d_reg  <= `LOG_ZERO;
            full_t_reg <= 1'b0;
            full_d_reg <= 1'b0;
        end else if (wr_busy_reg && wr_en) begin
            if (temp_last) begin
                if (ptr_t_adv >= size_t) begin
                    ptr_t_reg  <= `LOG_ZERO;
                    full_t_reg <= 1'b1;
                end else begin
                    ptr_t_reg  <= ptr_t_adv;
                end
            end
            if (data_last) begin
                if (ptr_d_adv >= size_d) begin
                    ptr_d_reg  <= `LOG_ZERO;
                    full_d_reg <= 1'b1;
                end else begin
                    ptr_d_reg  <= ptr_d_adv;
                end
            end
        end
    end

    // password bytes read as zero
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rd_data_reg <= 8'h00;
        end else if (host_rd_addr_in >= `PW_FIRST_ADDR
                     && host_rd_addr_in <= `PW_LAST_ADDR) begin
            rd_data_reg <= `PW_READ_BYTE;
        end else begin
            rd_data_reg <= mem_rd_data_in;
        end
    end

    assign gp_wr_ok_out = gp_wr_req_in;
    assign copy_ok_out  = copy_req_in
                          && !(copy_reg_page_in && active_reg);

    assign sample_req_out          = dev_inc;
    assign mission_active_flag_out = active_reg;
    assign memory_cleared_flag_out = cleared_reg;
    assign alarm_flags_out         = alarm_reg;
    assign alarmed_out             = |(alarm_reg & cfg_in.alarm_enable);
    assign mission_stamp_out       = stamp_reg;
    assign mission_count_out       = mission_cnt_reg;
    assign device_count_out        = device_cnt_reg;
    assign log_wr_out              = wr_reg;
    assign host_rd_data_out        = rd_data_reg;

endmodule // mission_datalog_sequencer

// ---- mission_datalog_checker.sv ----
// port-level assertions for the mission datalog sequencer
`timescale 1ns/1ps
`include "mission_datalog_consts.svh"
module mission_datalog_checker
    import mission_datalog_pkg::*;
#(
    parameter int CNT_W = 24
) (
    // clock, reset and stimulus
    input  wire logic              clk_in,
    input  wire logic              arst_n_in,
    input  wire logic [`RTC_W-1:0] rtc_now_in,
    input  wire log_cfg_s          cfg_in,
    input  wire logic              start_cmd_in,
    input  wire logic              clear_cmd_in,
    input  wire logic [15:0]       host_rd_addr_in,
    input  wire logic [7:0]        mem_rd_data_in,
    input  wire logic              gp_wr_req_in,
    input  wire logic              copy_req_in,
    input  wire logic              copy_reg_page_in,
    // observed outputs
    input  wire logic              sample_req_out,
    input  wire logic              mission_active_flag_out,
    input  wire logic              memory_cleared_flag_out,
    input  wire logic [3:0]        alarm_flags_out,
    input  wire logic              alarmed_out,
    input  wire logic [`RTC_W-1:0] mission_stamp_out,
    input  wire logic [CNT_W-1:0]  mission_count_out,
    input  wire logic [7:0]        host_rd_data_out,
    input  wire logic              gp_wr_ok_out,
    input  wire logic              copy_ok_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);

    // a start only counts from idle with some channel enabled
    wire logic go = start_cmd_in && !mission_active_flag_out &&
        (cfg_in.temperature_log_enable || cfg_in.data_log_enable);
    wire logic pw = host_rd_addr_in >= `PW_FIRST_ADDR &&
        host_rd_addr_in <= `PW_LAST_ADDR;

    a_start_active: assert property (go |=> mission_active_flag_out
        && !memory_cleared_flag_out) else $error("start flags wrong");
    a_start_stamp: assert property (go && cfg_in.start_delay == 0 &&
        !cfg_in.alarm_triggered_start |-> sample_req_out ##1
        mission_stamp_out == $past(rtc_now_in)) else $error("no stamp");
    a_clear_zero: assert property (clear_cmd_in &&
        !mission_active_flag_out |=> memory_cleared_flag_out &&
        mission_count_out == 0 && mission_stamp_out == 0 &&
        alarm_flags_out == 0) else $error("clear incomplete");
    a_count_step: assert property ($changed(mission_count_out) |->
        mission_count_out == $past(mission_count_out) + 1 ||
        $past(clear_cmd_in)) else $error("mission count jumped");
    a_alarm_flag_or: assert property (alarmed_out ==
        (|(alarm_flags_out & cfg_in.alarm_enable))) else $error("alarmed");
    a_gp_write_ok: assert property (gp_wr_ok_out == gp_wr_req_in)
        else $error("general write refused");
    a_copy_blocked: assert property (copy_req_in && copy_reg_page_in &&
        mission_active_flag_out |-> !copy_ok_out) else $error("copy let");
    a_pw_zero: assert property (pw |=> host_rd_data_out == 8'h00)
        else $error("password leaked");
    a_read_pass: assert property (!pw |=>
        host_rd_data_out == $past(mem_rd_data_in)) else $error("read");

    c_start: cover property (go);
    c_clear: cover property (clear_cmd_in);
    c_alarm: cover property (alarmed_out);
endmodule // mission_datalog_checker

bind mission_datalog_sequencer mission_datalog_checker #(.CNT_W(CNT_W))
    mission_datalog_checker_inst (.*);

// ---- log_mem_model.sv ----
// byte-wide log memory model
`timescale 1ns/1ps
module log_mem_model
    import mission_datalog_pkg::*;
(
    // write side
    input  wire logic        clk_in,
    input  wire log_wr_s     wr_in,
    // read side
    input  wire logic [15:0] addr_in,
    output logic [7:0]       data_out
);
    logic [7:0] mem [8192];

    // unwritten cells hold a pattern, nonzero except where the address mod 256 is 159
    initial for (int i = 0; i < 8192; i++) mem[i] = 8'(i * 37 + 5);
    always @(posedge clk_in) if (wr_in.we) mem[wr_in.addr] <= wr_in.data;
    assign data_out = mem[addr_in[12:0]];
endmodule // log_mem_model

// ---- tb_top.sv ----
// self-checking bench for the mission datalog sequencer
`timescale 1ns/1ps
module tb_top
    import mission_datalog_pkg::*;
;
    logic        clk_in = 0, arst_n_in = 0, sec_tick_in = 0;
    logic        start_cmd_in = 0, stop_cmd_in = 0, clear_cmd_in = 0;
    logic        oscillator_run_bit_in = 1; // kept running
    logic        gp_wr_req_in = 0, copy_req_in = 0, copy_reg_page_in = 0;
    logic [47:0] rtc_now_in = '0, mission_stamp_out;
    log_cfg_s    cfg_in = '0;
    logic [15:0] temp_value_in = '0, data_value_in = '0, host_rd_addr_in = '0;
    logic [3:0]  alarm_trip_in = '0, alarm_flags_out;
    logic [7:0]  mem_rd_data_in, host_rd_data_out;
    logic [23:0] mission_count_out, device_count_out;
    logic        sample_req_out, mission_active_flag_out, alarmed_out;
    logic        memory_cleared_flag_out, gp_wr_ok_out, copy_ok_out;
    log_wr_s     log_wr_out;
    logic [20:0] exp_q[$], wexp;
    int          n_mismatch = 0, n_tests = 0, seed = 74286, base = 0, dexp = 0;
    bit          te, de, wt, wd;
    // {temp on, data on, temp wide, data wide}
    logic [3:0]  mode_tab [6] = '{4'hA, 4'h4, 4'hC, 4'hF, 4'hD, 4'hE};

    mission_datalog_sequencer #(.CNT_W(24)) mission_datalog_sequencer_inst (.*);
    log_mem_model log_mem_model_inst (.clk_in(clk_in), .wr_in(log_wr_out),
        .addr_in(host_rd_addr_in), .data_out(mem_rd_data_in));

    initial forever #2 clk_in = ~clk_in;

    task automatic chk(input logic [47:0] seen, exp, input string nm);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s exp %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic end_of_test;
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // c: 0 start, 1 stop, 2 clear, 3 second tick
    task automatic cmd(input int c);
        {sec_tick_in, clear_cmd_in, stop_cmd_in, start_cmd_in} = 4'(1 << c);
        @(negedge clk_in);
        {sec_tick_in, clear_cmd_in, stop_cmd_in, start_cmd_in} = '0;
        repeat (7) @(negedge clk_in);
    endtask

    task automatic push(input int a, input logic [15:0] v, input bit w);
        if (w) begin
            exp_q.push_back({a[12:0], v[15:8]});
            exp_q.push_back({a[12:0] + 13'h1, v[7:0]});
        end else exp_q.push_back({a[12:0], v[7:0]});
    endtask

    task automatic load(input int k);
        temp_value_in = $random(seed);
        data_value_in = $random(seed);
        if (te) push(k * (wt + 1), temp_value_in, wt);
        if (de) push(base + k * (wd + 1), data_value_in, wd);
    endtask

    task automatic setmode(input logic [3:0] m);
        {te, de, wt, wd} = m;
        {cfg_in.temperature_log_enable, cfg_in.data_log_enable} = {te, de};
        {cfg_in.temp_wide, cfg_in.data_wide} = {wt, wd};
        base = !(te && de) ? 0 : (wt == wd) ? 'h1000 : 'h1F00 - 2560 * (wd + 1);
        cmd(1);
        cmd(2);
    endtask

    always @(negedge clk_in) begin
        if (log_wr_out.we === 1'b1) begin
            wexp = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
            chk({log_wr_out.addr, log_wr_out.data}, wexp, "log write");
        end
    end

    initial begin
        repeat (6) @(negedge clk_in);
        arst_n_in = 1;
        cmd(2);
        chk(memory_cleared_flag_out, 1, "cleared");
        cmd(0);
        chk(mission_active_flag_out, 0, "empty start");
        {cfg_in.sample_rate, cfg_in.fast_rate_select} = {14'h0001, 1'b1};
        foreach (mode_tab[m]) begin
            setmode(mode_tab[m]);
            load(0);
            rtc_now_in = {$random(seed), $random(seed)};
            cmd(0);
            chk({mission_active_flag_out, memory_cleared_flag_out}, 2, "flags");
            chk(mission_stamp_out, rtc_now_in, "stamp");
            load(1);
            cmd(3);
            chk(mission_count_out, 2, "mission count");
            dexp += 2;
            chk(device_count_out, dexp, "device count");
        end
        // 60 second ticks hold one minute boundary
        cfg_in.fast_rate_select = 0;
        load(2);
        repeat (60) cmd(3);
        chk(mission_count_out, 3, "minute count");
        cfg_in.fast_rate_select = 1;
        for (int w = 0; w < 2; w++) begin
            cfg_in.wrap_enable = w[0];
            setmode(4'hA);
            load(0);
            cmd(0);
            for (int k = 1; k <= 4096; k++) begin
                if (k < 4096 || w) load(k);
                cmd(3);
            end
        end
        {cfg_in.alarm_triggered_start, cfg_in.alarm_enable} = 5'h11;
        setmode(4'h8);
        cmd(0);
        alarm_trip_in = 4'h1;
        load(0);
        cmd(3);
        alarm_trip_in = 4'h0;
        chk(mission_count_out, 0, "alarm entry count");
        chk(mission_stamp_out, 0, "alarm entry stamp");
        chk(alarmed_out, 1, "alarmed");
        host_rd_addr_in = 16'h0000;
        {gp_wr_req_in, copy_req_in, copy_reg_page_in} = 3'h7;
        @(negedge clk_in);
        chk(host_rd_data_out, temp_value_in[7:0], "log read");
        chk({gp_wr_ok_out, copy_ok_out}, 2, "mission writes");
        host_rd_addr_in = 16'h0230;
        @(negedge clk_in);
        chk(host_rd_data_out, 0, "password read");
        load(1);
        rtc_now_in = ~rtc_now_in;
        cmd(3);
        chk(mission_count_out, 1, "alarm count");
        chk(mission_stamp_out, rtc_now_in, "alarm stamp");
        chk(exp_q.size(), 0, "pending writes");
        end_of_test();
    end

    // wrap runs take about 66k cycles
    initial begin
        #400000;
        n_mismatch++;
        end_of_test();
    end
endmodule // tb_top
